// file: hw/als_consts.svh
`ifndef ALS_CONSTS_SVH
`define ALS_CONSTS_SVH

// Bus addresses, as the full first byte of a transfer.
`define ALS_BUS_WR_ADDR 8'h26
`define ALS_BUS_RD_ADDR 8'h27

// Register indices.
`define ALS_REG_CFG 8'h84
`define ALS_REG_RES_HI 8'h85
`define ALS_REG_RES_LO 8'h86

// Configuration register fields and reset value.
`define ALS_CFG_MODE_BIT 7
`define ALS_CFG_AVG_MSB 2
`define ALS_CFG_AVG_LSB 0
`define ALS_CFG_RESET 8'h00

// Timing: figures in their own units, cycle counts derived from the clock period.
`define ALS_CLK_PERIOD_NS 25
`define ALS_FRAME_MS 100
`define ALS_MEAS_US 300
`define ALS_FRAME_CYC ((`ALS_FRAME_MS * 1000000) / `ALS_CLK_PERIOD_NS)
`define ALS_MEAS_CYC ((`ALS_MEAS_US * 1000) / `ALS_CLK_PERIOD_NS)

`endif

// file: hw/als_conv_engine.sv
`timescale 1ns/100ps
`include "als_consts.svh"

module als_conv_engine #(
  parameter int FRAME_CYCLES = `ALS_FRAME_CYC,
  parameter int MEAS_CYCLES = `ALS_MEAS_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [15:0] adc_sample,
  als_meas_if.engine m
);
  localparam int FW = $clog2(FRAME_CYCLES + 1);
  localparam int MW = $clog2(MEAS_CYCLES + 1);

  als_pkg::conv_state_e st_q, st_d;
  logic [FW-1:0] frame_cnt_q, frame_cnt_d;
  logic [MW-1:0] meas_cnt_q, meas_cnt_d;
  logic [7:0] n_q, n_d;
  logic [22:0] acc_q, acc_d;
  logic [15:0] pend_q, pend_d;
  logic [15:0] res_q, res_d;
  logic stb_q, stb_d;
  logic mode_q;
  logic meas_done, set_done, frame_end, restart;
  logic [22:0] sum, avg_full;
  logic [7:0] avg_num;

  assign avg_num = 8'h01 << m.avg_code;
  assign meas_done = (st_q == als_pkg::CONV_MEASURE) && (meas_cnt_q == MW'(MEAS_CYCLES - 1));
  // A smaller averaging code arriving mid-set ends that set at the first measurement end where its measurements reach the new count, instead of wrapping.
  assign set_done = meas_done && (n_q >= avg_num - 8'h01);
  assign frame_end = frame_cnt_q == FW'(FRAME_CYCLES - 1);
  assign restart = mode_q != m.cont_mode;
  assign sum = acc_q + {7'h00, adc_sample};
  assign avg_full = sum >> m.avg_code;

  always_comb begin
    st_d = st_q;
    meas_cnt_d = meas_cnt_q;
    n_d = n_q;
    acc_d = acc_q;
    pend_d = pend_q;
    res_d = res_q;
    stb_d = 1'b0;
    frame_cnt_d = frame_end ? '0 : frame_cnt_q + FW'(1); // [R5]
    case (st_q)
      als_pkg::CONV_MEASURE: begin
        meas_cnt_d = meas_cnt_q + MW'(1); // [R6]
        if (meas_done) begin
          meas_cnt_d = '0; // [R9]
          acc_d = sum;
          n_d = n_q + 8'h01;
          if (set_done) begin
            acc_d = '0; // [R7]
            n_d = 8'h00;
            if (m.cont_mode) begin
              res_d = avg_full[15:0]; // [R12]
              stb_d = 1'b1;
            end else begin
              pend_d = avg_full[15:0];
              st_d = als_pkg::CONV_HOLD;
            end
          end
        end
      end
      als_pkg::CONV_HOLD: begin
        if (frame_end) begin
          res_d = pend_q; // [R8]
          stb_d = 1'b1;
          st_d = als_pkg::CONV_MEASURE;
          meas_cnt_d = '0;
        end
      end
      default: st_d = als_pkg::CONV_MEASURE;
    endcase
    // A mode change abandons the set in progress and starts a fresh frame, keeping the old result.
    if (restart) begin
      st_d = als_pkg::CONV_MEASURE;
      meas_cnt_d = '0;
      frame_cnt_d = '0;
      n_d = 8'h00;
      acc_d = '0;
      stb_d = 1'b0;
      res_d = res_q; // [R12]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= als_pkg::CONV_MEASURE;
      frame_cnt_q <= '0;
      meas_cnt_q <= '0;
      n_q <= 8'h00;
      acc_q <= '0;
      pend_q <= 16'h0000;
      res_q <= 16'h0000;
      stb_q <= 1'b0;
      mode_q <= 1'b0;
    end else begin
      st_q <= st_d;
      frame_cnt_q <= frame_cnt_d;
      meas_cnt_q <= meas_cnt_d;
      n_q <= n_d;
      acc_q <= acc_d;
      pend_q <= pend_d;
      res_q <= res_d;
      stb_q <= stb_d;
      mode_q <= m.cont_mode;
    end
  end

  assign m.result = res_q;
  assign m.result_stb = stb_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_frame_bound;
    frame_cnt_q <= FW'(FRAME_CYCLES - 1);
  endproperty
  a_frame_bound: assert property (p_frame_bound) else $error("frame counter overran"); // [R5]

  property p_meas_step;
    st_q == als_pkg::CONV_MEASURE && !meas_done && !restart
      |=> meas_cnt_q == $past(meas_cnt_q) + MW'(1);
  endproperty
  a_meas_step: assert property (p_meas_step) else $error("measurement count stalled"); // [R6]

  property p_avg;
    m.cont_mode && set_done && !restart |=> m.result_stb && m.result == $past(avg_full[15:0]);
  endproperty
  a_avg: assert property (p_avg) else $error("average not published"); // [R7]

  property p_frame_pub;
    !m.cont_mode && !mode_q && m.result_stb |-> frame_cnt_q == '0;
  endproperty
  a_frame_pub: assert property (p_frame_pub) else $error("result out of frame end"); // [R8]

  property p_back2back;
    m.cont_mode && meas_done && !restart |=> st_q == als_pkg::CONV_MEASURE && meas_cnt_q == '0;
  endproperty
  a_back2back: assert property (p_back2back) else $error("gap between measurements"); // [R9]

  property p_stable;
    $changed(m.result) |-> m.result_stb;
  endproperty
  a_stable: assert property (p_stable) else $error("result changed without strobe"); // [R12]
endmodule : als_conv_engine

// file: hw/als_meas_if.sv
`timescale 1ns/100ps

interface als_meas_if;
  logic cont_mode;
  logic [2:0] avg_code;
  logic [15:0] result;
  logic result_stb;

  modport engine (
    input cont_mode,
    input avg_code,
    output result,
    output result_stb
  );

  modport ctrl (
    output cont_mode,
    output avg_code,
    input result,
    input result_stb
  );
endinterface : als_meas_if

// file: hw/als_pkg.sv
package als_pkg;

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_RX_ADDR,
    I2C_RX_DATA,
    I2C_ACK,
    I2C_TX,
    I2C_MACK,
    I2C_TX_NEXT
  } i2c_state_e;

  typedef enum logic {
    CONV_MEASURE,
    CONV_HOLD
  } conv_state_e;

endpackage : als_pkg

// file: hw/als_readout.sv
// Notes on behaviour
// [R1] Host selects the result high byte by writing address 26h, then index 85h.
// [R2] A read at address 27h after that returns the result high byte first.
// [R3] The next read byte returns the low byte at index 86 without re-indexing.
// [R4] Configuration bit 7 picks framed standard mode (0) or continuous mode (1).
// [R5] Standard mode performs the whole averaged set inside one 100 ms frame.
// [R6] Each single measurement lasts about 300 us.
// [R7] The number of measurements set by averaging, up to 128, is averaged.
// [R8] In standard mode the averaged result appears only when the frame ends.
// [R9] Continuous mode starts each measurement right after the previous one.
// [R10] Stop or repeated start between index write and read are both accepted.
// [R11] The register pointer advances by one after each read data byte.
// [R12] Results update only once per complete averaged set, both bytes together.
`timescale 1ns/100ps
`include "als_consts.svh"

module als_readout #(
  parameter int FRAME_CYCLES = `ALS_FRAME_CYC,
  parameter int MEAS_CYCLES = `ALS_MEAS_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output wire logic sda_o,
  output wire logic sda_oe,
  input wire logic [15:0] adc_sample
);
  als_meas_if m ();

  als_pkg::i2c_state_e st_q, st_d;
  logic scl_q, sda_q;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sr_q, sr_d;
  logic [7:0] ptr_q, ptr_d;
  logic rw_q, rw_d;
  logic idx_q, idx_d;
  logic [7:0] cfg_q, cfg_d;
  logic oe_q, oe_d;
  logic scl_rise, scl_fall, start, stop;
  logic load_tx, wr_cfg;
  logic [7:0] rd_byte;

  function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] cfg,
                                          input logic [15:0] res);
    case (idx)
      `ALS_REG_CFG: reg_read = cfg;
      `ALS_REG_RES_HI: reg_read = res[15:8];
      `ALS_REG_RES_LO: reg_read = res[7:0];
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  assign scl_rise = scl_i && !scl_q;
  assign scl_fall = !scl_i && scl_q;
  assign start = scl_i && scl_q && sda_q && !sda_i;
  assign stop = scl_i && scl_q && !sda_q && sda_i;
  assign rd_byte = reg_read(ptr_q, cfg_q, m.result);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sr_d = sr_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    idx_d = idx_q;
    cfg_d = cfg_q;
    oe_d = oe_q;
    load_tx = 1'b0;
    wr_cfg = 1'b0;
    case (st_q)
      als_pkg::I2C_IDLE: st_d = als_pkg::I2C_IDLE;
      als_pkg::I2C_RX_ADDR, als_pkg::I2C_RX_DATA: begin
        if (scl_rise) begin
          sr_d = {sr_q[6:0], sda_i};
          cnt_d = cnt_q + 4'h1;
        end else if (scl_fall && cnt_q == 4'h8) begin
          cnt_d = 4'h0;
          if (st_q == als_pkg::I2C_RX_ADDR) begin
            if (sr_q == `ALS_BUS_WR_ADDR) begin
              rw_d = 1'b0; // [R1]
              idx_d = 1'b1;
              oe_d = 1'b1;
              st_d = als_pkg::I2C_ACK;
            end else if (sr_q == `ALS_BUS_RD_ADDR) begin
              rw_d = 1'b1; // [R2]
              oe_d = 1'b1;
              st_d = als_pkg::I2C_ACK;
            end else begin
              st_d = als_pkg::I2C_IDLE;
            end
          end else begin
            if (idx_q) begin
              ptr_d = sr_q; // [R1]
              idx_d = 1'b0;
            end else begin
              wr_cfg = ptr_q == `ALS_REG_CFG;
              if (wr_cfg) begin
                cfg_d = sr_q;
              end
              ptr_d = ptr_q + 8'h01;
            end
            oe_d = 1'b1;
            st_d = als_pkg::I2C_ACK;
          end
        end
      end
      als_pkg::I2C_ACK: begin
        if (scl_fall) begin
          if (rw_q) begin
            load_tx = 1'b1;
          end else begin
            oe_d = 1'b0;
            st_d = als_pkg::I2C_RX_DATA;
          end
        end
      end
      als_pkg::I2C_TX: begin
        if (scl_rise) begin
          cnt_d = cnt_q + 4'h1;
        end else if (scl_fall) begin
          if (cnt_q == 4'h8) begin
            oe_d = 1'b0;
            st_d = als_pkg::I2C_MACK;
          end else begin
            sr_d = {sr_q[6:0], 1'b0};
            oe_d = !sr_q[6];
          end
        end
      end
      als_pkg::I2C_MACK: begin
        // A not-acknowledge ends the read; the bus is already released.
        if (scl_rise) begin
          st_d = sda_i ? als_pkg::I2C_IDLE : als_pkg::I2C_TX_NEXT;
        end
      end
      als_pkg::I2C_TX_NEXT: begin
        if (scl_fall) begin
          load_tx = 1'b1;
        end
      end
      default: st_d = als_pkg::I2C_IDLE;
    endcase
    if (load_tx) begin
      sr_d = rd_byte; // [R2] [R3]
      oe_d = !rd_byte[7];
      ptr_d = ptr_q + 8'h01; // [R11]
      cnt_d = 4'h0;
      st_d = als_pkg::I2C_TX;
    end
    // The pointer survives both, so the read may follow either way.
    if (stop) begin
      st_d = als_pkg::I2C_IDLE; // [R10]
      oe_d = 1'b0;
    end
    if (start) begin
      st_d = als_pkg::I2C_RX_ADDR; // [R10]
      cnt_d = 4'h0;
      oe_d = 1'b0;
      idx_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= als_pkg::I2C_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      idx_q <= 1'b0;
      cfg_q <= `ALS_CFG_RESET;
      oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      scl_q <= scl_i;
      sda_q <= sda_i;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      idx_q <= idx_d;
      cfg_q <= cfg_d;
      oe_q <= oe_d;
    end
  end

  assign m.cont_mode = cfg_q[`ALS_CFG_MODE_BIT]; // [R4]
  assign m.avg_code = cfg_q[`ALS_CFG_AVG_MSB:`ALS_CFG_AVG_LSB];
  assign sda_o = 1'b0;
  assign sda_oe = oe_q;

  als_conv_engine #(
    .FRAME_CYCLES(FRAME_CYCLES),
    .MEAS_CYCLES(MEAS_CYCLES)
  ) u_conv (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .adc_sample(adc_sample),
    .m(m.engine)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_load_hi;
    load_tx && ptr_q == `ALS_REG_RES_HI;
  endsequence

  sequence s_load_lo;
    load_tx && ptr_q == `ALS_REG_RES_LO;
  endsequence

  property p_hi_first;
    s_load_hi |=> sr_q == $past(m.result[15:8]) && ptr_q == `ALS_REG_RES_LO;
  endproperty
  a_hi_first: assert property (p_hi_first) else $error("high byte not sent first"); // [R2]

  property p_lo_next;
    s_load_lo |=> sr_q == $past(m.result[7:0]) && oe_q == !$past(m.result[7]);
  endproperty
  a_lo_next: assert property (p_lo_next) else $error("low byte not sent next"); // [R3]

  property p_ptr_inc;
    load_tx |=> ptr_q == $past(ptr_q) + 8'h01 && st_q == als_pkg::I2C_TX;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance"); // [R11]

  property p_restart;
    start |=> st_q == als_pkg::I2C_RX_ADDR && !oe_q && cnt_q == 4'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("start not honoured"); // [R10]

  property p_stop;
    stop && !start |=> st_q == als_pkg::I2C_IDLE && !oe_q && ptr_q == $past(ptr_q);
  endproperty
  a_stop: assert property (p_stop) else $error("stop lost the pointer"); // [R10]

  property p_mode;
    wr_cfg && !start && !stop |=> m.cont_mode == $past(sr_q[`ALS_CFG_MODE_BIT]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bit not applied"); // [R4]
endmodule : als_readout

// file: verif/i2c_host_model.sv
`timescale 1ns/100ps

// Host side of the bus: open drain, so a released SDA reads high through the pull-up.
module i2c_host_model (
  input wire logic ref_clk,
  input wire logic sda_oe,
  input wire logic sda_o,
  output logic scl = 1'b1,
  output logic sda_w
);
  logic sda_h = 1'b1;

  assign sda_w = sda_h & (sda_oe ? sda_o : 1'b1);

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // Serves as a first start and as a repeated start.
  task automatic start();
    tick(1);
    sda_h <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_h <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    tick(1);
    sda_h <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_h <= 1'b1;
    tick(4);
  endtask : stop

  // SDA moves one cycle after SCL falls and is sampled at the end of the high phase.
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_h <= b;
    tick(3);
    scl <= 1'b1;
    tick(4);
    r = sda_w;
    scl <= 1'b0;
  endtask : bit_io

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte

  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask : rbyte
endmodule : i2c_host_model

// file: verif/test_ambient_light_conversion_readout.sv
`timescale 1ns/100ps

module test_ambient_light_conversion_readout;
  localparam int FRAME = 2000;
  localparam int MEAS = 3;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] adc_sample = 16'h0000;
  logic scl;
  logic sda_w;
  logic sda_oe;
  logic sda_o;
  logic alt_en = 1'b0;
  logic [15:0] alt_a = 16'h0000;
  logic [15:0] alt_b = 16'h0000;
  int alt_cnt = 0;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #12.5 ref_clk = ~ref_clk;

  i2c_host_model host (
    .ref_clk(ref_clk),
    .sda_oe(sda_oe),
    .sda_o(sda_o),
    .scl(scl),
    .sda_w(sda_w)
  );

  // Samples alternate once per measurement when enabled, so any even-length set averages the pair.
  always @(posedge ref_clk) begin
    alt_cnt <= (alt_cnt == 2 * MEAS - 1) ? 0 : alt_cnt + 1;
    adc_sample <= (alt_en && alt_cnt >= MEAS) ? alt_b : alt_a;
  end

  als_readout #(.FRAME_CYCLES(FRAME), .MEAS_CYCLES(MEAS)) DUT (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .scl_i(scl),
    .sda_i(sda_w),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .adc_sample(adc_sample)
  );

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  // Average of a set of 2^code samples alternating between two values, built as a queue.
  function automatic logic [15:0] avg_model(input int s0, input int s1, input int code);
    int q[$];
    int sum;
    sum = 0;
    for (int i = 0; i < (1 << code); i++) begin
      q.push_back((i % 2) ? s1 : s0);
    end
    foreach (q[i]) begin
      sum += q[i];
    end
    return 16'(sum >> code);
  endfunction : avg_model

  task automatic set_ptr(input logic [7:0] idx, input bit rs);
    logic a;
    host.start();
    host.wbyte(8'h26, a);
    check({23'h0, a}, {23'h0, 1'b1});
    host.wbyte(idx, a);
    check({23'h0, a}, {23'h0, 1'b1});
    if (!rs) begin
      host.stop();
    end
  endtask : set_ptr

  // Three bytes in one read: pointer, pointer + 1, pointer + 2.
  task automatic rd3(output logic [23:0] v);
    logic a;
    host.start();
    host.wbyte(8'h27, a);
    check({23'h0, a}, {23'h0, 1'b1});
    host.rbyte(1'b0, v[23:16]);
    host.rbyte(1'b0, v[15:8]);
    host.rbyte(1'b1, v[7:0]);
    host.stop();
  endtask : rd3

  task automatic wcfg(input logic [7:0] c);
    logic a;
    set_ptr(8'h84, 1'b1);
    host.wbyte(c, a);
    check({23'h0, a}, {23'h0, 1'b1});
    host.stop();
  endtask : wcfg

  initial begin
    logic [23:0] v;
    logic [15:0] a_val;
    logic [15:0] b_val;
    logic [15:0] exp_res;
    logic ack;
    int code;
    void'($urandom(32'h5b07));
    a_val = 16'($urandom()) | 16'h0001;
    b_val = ~a_val;
    @(posedge ref_clk);
    alt_a <= a_val;
    repeat (9) @(posedge ref_clk);
    sys_rst <= 1'b0;
    host.tick(2);
    wcfg(8'h07);
    set_ptr(8'h85, 1'b0);
    rd3(v);
    check(v, {16'h0000, 8'h00});
    while (cyc < FRAME + 100) begin
      host.tick(1);
    end
    set_ptr(8'h85, 1'b1);
    rd3(v);
    check(v, {avg_model(a_val, a_val, 7), 8'h00});
    @(posedge ref_clk);
    alt_a <= b_val;
    set_ptr(8'h85, 1'b0);
    rd3(v);
    check(v, {a_val, 8'h00});
    $display("test standard frame done");
    wcfg(8'h80);
    set_ptr(8'h84, 1'b0);
    rd3(v);
    check(v, {8'h80, b_val});
    $display("test continuous mode done");
    for (int k = 0; k < 4; k++) begin
      code = 2 * k + 1;
      a_val = 16'($urandom());
      b_val = 16'($urandom());
      exp_res = avg_model(a_val, b_val, code);
      wcfg(8'h80 | 8'(code));
      @(posedge ref_clk);
      alt_a <= a_val;
      alt_b <= b_val;
      alt_en <= 1'b1;
      host.tick(2 * MEAS * 128 + 10);
      set_ptr(8'h85, 1'b1);
      rd3(v);
      check(v, {exp_res, 8'h00});
    end
    $display("test averaging sets done");
    host.start();
    host.wbyte(8'h50, ack);
    check({23'h0, ack}, {23'h0, 1'b0});
    host.stop();
    set_ptr(8'h85, 1'b1);
    host.wbyte(8'h5a, ack);
    host.stop();
    set_ptr(8'h85, 1'b0);
    rd3(v);
    check(v, {exp_res, 8'h00});
    $display("test refusals done");
    summarize();
  end
endmodule : test_ambient_light_conversion_readout
